// ---- hdl/ipdc_cfg.svh ----
/*
 Timing counts, offsets, field positions and reset values for the power control block.
 Assumes inclusion by bare name from hdl/.
*/
`ifndef IPDC_CFG_SVH
`define IPDC_CFG_SVH
`define IPDC_POWER_CONTROL_ADDR 8'h87
`define IPDC_BIT_IDLE 0
`define IPDC_BIT_PDOWN 1
`define IPDC_BIT_UFLAG_A 2
`define IPDC_BIT_UFLAG_B 3
`define IPDC_BIT_SUPPLY 4
`define IPDC_BIT_RSVD 5
`define IPDC_BIT_FRAME 6
`define IPDC_BIT_BAUD 7
`define IPDC_POWER_CONTROL_RESET 8'h10
`define IPDC_OSC_PERIOD_NS 50
`define IPDC_WARM_RST_OSC_PERIODS 24
`define IPDC_WARM_RST_CYCLES 24
`define IPDC_OSC_START_CYCLES 16
`define IPDC_RAM_BLOCK_CYCLES 4
`endif

// ---- hdl/ipdc_pkg.sv ----
/*
 Types shared by the power control block.
 Assumes ipdc_cfg.svh is available for constants.
*/
package ipdc_pkg;
   typedef enum logic [4:0] {
      IPDC_RUN = 5'b0_0001,
      IPDC_IDLE = 5'b0_0010,
      IPDC_PDOWN = 5'b0_0100,
      IPDC_OSC_WAIT = 5'b0_1000,
      IPDC_RELEASE_WAIT = 5'b1_0000
   } ipdc_mode_t;
   typedef struct packed {
      logic baud_doubler;
      logic serial_frame_select;
      logic reserved;
      logic supply_on_flag;
      logic user_flag_b;
      logic user_flag_a;
      logic powerdown_request;
      logic idle_request;
   } ipdc_power_control_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ipdc_sfr_req_t;
endpackage

// ---- hdl/ipdc_clk_gate.sv ----
/*
 Glitch-free clock enable gate: the enable changes only when the divider strobe fires.
 Assumes one system clock; gated domains use the enable output as a clock enable.
*/
`timescale 1ns/1ps
module ipdc_clk_gate (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic run_in,
   input wire logic strobe_in,
   output logic en_out
);
   typedef struct packed {
      logic en;
   } ipdc_gate_state_t;
   ipdc_gate_state_t state_reg;
   ipdc_gate_state_t state_next;
   // The enable only moves on a strobe, so no partial pulse reaches a gated domain.
   always_comb begin
      state_next = state_reg;
      if (strobe_in) begin
         state_next.en = run_in;
      end
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_reg <= '{en: 1'b1};
      end else begin
         state_reg <= state_next;
      end
   end
   assign en_out = state_reg.en;
endmodule // ipdc_clk_gate

// ---- hdl/ipdc_ctrl.sv ----
/*
 Idle and power-down control with the power control register.
 Assumes the CPU reaches the register over its SFR port and that the
 reset pin, interrupt pins and converter completion are synchronous.
*/
// How it works
// - Idle stops the CPU clock cleanly; peripherals keep clocking.
// - Idle preserves PC, PSW, SFRs and RAM.
// - Writing bit 0 enters Idle after the writing instruction.
// - Both bits set enters Power-down; no Idle afterwards.
// - Enabled interrupt clears idle bit and restores CPU clock.
// - Reset pin clears idle bit immediately, restoring the CPU clock.
// - Internal RAM blocked during the reset wake interval; ports allowed.
// - Converter completion ends Idle entered through converter idle.
// - Power-down stops oscillator and all clocks; state preserved.
// - Writing bit 1 enters Power-down after the writing instruction.
// - Only the two external interrupts and the reset pin wake Power-down; clocks restart.
// - Execution resumes only after the waking interrupt input releases.
// - External interrupt wake leaves SFRs and RAM unchanged.
// - Reset pin clears power-down bit, restarts clocks, then resets.
// - Reset wake reinitialises SFRs, keeps RAM.
// - Ports drive high in reset; hold latched data in Idle and Power-down.
// - Bit 4 set on power-up, settable by software, cleared by software.
// - Bits 3 and 2 are plain software flags.
// - Register resets to 00X1 0000, bit 5 reserved, not bit addressable.
`timescale 1ns/1ps
`include "ipdc_cfg.svh"
module ipdc_ctrl #(
   parameter int unsigned WARM_RST_CYCLES = `IPDC_WARM_RST_CYCLES,
   parameter int unsigned OSC_START_CYCLES = `IPDC_OSC_START_CYCLES,
   parameter int unsigned RAM_BLOCK_CYCLES = `IPDC_RAM_BLOCK_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic power_on_in,
   input wire logic reset_pin_in,
   input wire ipdc_pkg::ipdc_sfr_req_t sfr_req_in,
   input wire logic instr_done_in,
   input wire logic irq_pending_in,
   input wire logic ext_irq_a_n_in,
   input wire logic ext_irq_b_n_in,
   input wire logic ext_irq_a_en_in,
   input wire logic ext_irq_b_en_in,
   input wire logic adc_idle_mode_in,
   input wire logic adc_done_in,
   input wire logic [7:0] port_latch_in,
   output logic [7:0] sfr_rdata_out,
   output logic cpu_clk_en_out,
   output logic periph_clk_en_out,
   output logic osc_run_out,
   output logic cpu_hold_out,
   output logic internal_reset_out,
   output logic ram_block_out,
   output logic baud_doubler_out,
   output logic serial_frame_select_out,
   output logic [7:0] port_out
);
   localparam int unsigned CNT_W = 16;
   localparam logic [CNT_W-1:0] WARM_MAX = CNT_W'(WARM_RST_CYCLES - 1);
   localparam logic [CNT_W-1:0] OSC_MAX = CNT_W'(OSC_START_CYCLES - 1);
   localparam logic [CNT_W-1:0] RAM_MAX = CNT_W'(RAM_BLOCK_CYCLES - 1);

   typedef struct packed {
      ipdc_pkg::ipdc_mode_t mode;
      ipdc_pkg::ipdc_power_control_t power_control;
      logic idle_pending;
      logic pdown_pending;
      logic adc_idle;
      logic [CNT_W-1:0] osc_cnt;
      logic [CNT_W-1:0] rst_cnt;
      logic [CNT_W-1:0] ram_cnt;
      logic reset_wake;
      logic internal_reset;
      logic ram_block;
      logic cpu_run;
      logic periph_run;
      logic osc_run;
      logic cpu_hold;
      logic [7:0] rdata;
      logic [7:0] port;
      logic baud;
      logic frame;
   } ipdc_state_t;

   ipdc_state_t state_reg;
   ipdc_state_t state_next;
   logic cpu_gate_en;
   logic periph_gate_en;
   logic power_control_sel;
   logic ext_wake;
   logic ext_level;

   // ==========================================================
   // Clock gates
   // ==========================================================
   ipdc_clk_gate u_cpu_gate (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .run_in(state_reg.cpu_run),
      .strobe_in(1'b1),
      .en_out(cpu_gate_en)
   );
   ipdc_clk_gate u_periph_gate (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .run_in(state_reg.periph_run),
      .strobe_in(1'b1),
      .en_out(periph_gate_en)
   );

   assign power_control_sel = (sfr_req_in.addr == `IPDC_POWER_CONTROL_ADDR);
   assign ext_level = (~ext_irq_a_n_in & ext_irq_a_en_in) | (~ext_irq_b_n_in & ext_irq_b_en_in);
   assign ext_wake = ext_level;

   // ==========================================================
   // Mode control
   // ==========================================================
   always_comb begin
      state_next = state_reg;
      state_next.cpu_hold = 1'b0;
      // Register write: software fields plus the two mode requests.
      if (sfr_req_in.wr && power_control_sel && state_reg.cpu_run && !state_reg.ram_block) begin
         state_next.power_control.baud_doubler = sfr_req_in.wdata[`IPDC_BIT_BAUD];
         state_next.power_control.serial_frame_select = sfr_req_in.wdata[`IPDC_BIT_FRAME];
         state_next.power_control.reserved = sfr_req_in.wdata[`IPDC_BIT_RSVD];
         state_next.power_control.supply_on_flag = sfr_req_in.wdata[`IPDC_BIT_SUPPLY];
         state_next.power_control.user_flag_b = sfr_req_in.wdata[`IPDC_BIT_UFLAG_B];
         state_next.power_control.user_flag_a = sfr_req_in.wdata[`IPDC_BIT_UFLAG_A];
         state_next.power_control.idle_request = sfr_req_in.wdata[`IPDC_BIT_IDLE];
         state_next.power_control.powerdown_request = sfr_req_in.wdata[`IPDC_BIT_PDOWN];
         state_next.idle_pending = sfr_req_in.wdata[`IPDC_BIT_IDLE];
         state_next.pdown_pending = sfr_req_in.wdata[`IPDC_BIT_PDOWN];
         state_next.adc_idle = adc_idle_mode_in;
      end
      if (sfr_req_in.rd && power_control_sel) begin
         state_next.rdata = state_reg.power_control;
      end
      // Reset pin: clears both mode bits at once and restores clocks.
      if (reset_pin_in) begin
         if (state_reg.rst_cnt != WARM_MAX) begin
            state_next.rst_cnt = state_reg.rst_cnt + CNT_W'(1);
         end
         if (state_reg.mode != ipdc_pkg::IPDC_RUN) begin
            state_next.reset_wake = 1'b1;
         end
         state_next.power_control.idle_request = 1'b0;
         state_next.power_control.powerdown_request = 1'b0;
         state_next.idle_pending = 1'b0;
         state_next.pdown_pending = 1'b0;
         state_next.osc_run = 1'b1;
         state_next.periph_run = 1'b1;
         state_next.cpu_run = 1'b1;
         state_next.mode = ipdc_pkg::IPDC_RUN;
      end else begin
         state_next.rst_cnt = '0;
      end
      // Warm reset takes over once the pin has stood for the least time.
      if (reset_pin_in && state_reg.rst_cnt == WARM_MAX) begin
         state_next.internal_reset = 1'b1;
         state_next.reset_wake = 1'b0;
         state_next.ram_block = 1'b0;
         state_next.power_control.baud_doubler = 1'b0;
         state_next.power_control.serial_frame_select = 1'b0;
         state_next.power_control.user_flag_b = 1'b0;
         state_next.power_control.user_flag_a = 1'b0;
         state_next.port = 8'hFF;
      end else begin
         state_next.internal_reset = 1'b0;
      end
      // RAM is blocked while execution briefly resumes after a reset wake.
      if (state_reg.reset_wake && !state_reg.internal_reset) begin
         state_next.ram_block = 1'b1;
         if (state_reg.ram_cnt != RAM_MAX) begin
            state_next.ram_cnt = state_reg.ram_cnt + CNT_W'(1);
         end
      end else begin
         state_next.ram_cnt = '0;
      end
      if (!reset_pin_in) begin
         case (state_reg.mode)
            ipdc_pkg::IPDC_RUN: begin
               if (instr_done_in && state_reg.pdown_pending) begin
                  state_next.mode = ipdc_pkg::IPDC_PDOWN;
                  state_next.cpu_run = 1'b0;
                  state_next.periph_run = 1'b0;
                  state_next.osc_run = 1'b0;
                  state_next.pdown_pending = 1'b0;
                  state_next.idle_pending = 1'b0;
               end else if (instr_done_in && state_reg.idle_pending) begin
                  state_next.mode = ipdc_pkg::IPDC_IDLE;
                  state_next.cpu_run = 1'b0;
                  state_next.idle_pending = 1'b0;
               end
            end
            ipdc_pkg::IPDC_IDLE: begin
               if (irq_pending_in || (state_reg.adc_idle && adc_done_in)) begin
                  state_next.power_control.idle_request = 1'b0;
                  state_next.cpu_run = 1'b1;
                  state_next.adc_idle = 1'b0;
                  state_next.mode = ipdc_pkg::IPDC_RUN;
               end
            end
            ipdc_pkg::IPDC_PDOWN: begin
               if (ext_wake) begin
                  state_next.power_control.powerdown_request = 1'b0;
                  state_next.power_control.idle_request = 1'b0;
                  state_next.osc_run = 1'b1;
                  state_next.osc_cnt = '0;
                  state_next.mode = ipdc_pkg::IPDC_OSC_WAIT;
               end
            end
            ipdc_pkg::IPDC_OSC_WAIT: begin
               state_next.osc_cnt = state_reg.osc_cnt + CNT_W'(1);
               if (state_reg.osc_cnt == OSC_MAX) begin
                  state_next.periph_run = 1'b1;
                  state_next.mode = ipdc_pkg::IPDC_RELEASE_WAIT;
               end
            end
            ipdc_pkg::IPDC_RELEASE_WAIT: begin
               state_next.cpu_hold = 1'b1;
               if (!ext_level) begin
                  state_next.cpu_run = 1'b1;
                  state_next.cpu_hold = 1'b0;
                  state_next.mode = ipdc_pkg::IPDC_RUN;
               end
            end
            default: begin
               state_next.mode = ipdc_pkg::IPDC_RUN;
            end
         endcase
      end
      if (state_next.mode == ipdc_pkg::IPDC_OSC_WAIT) begin
         state_next.cpu_hold = 1'b1;
      end
      // Ports keep latched data outside reset; RAM and SFRs are untouched here.
      if (!state_next.internal_reset) begin
         state_next.port = port_latch_in;
      end
      if (power_on_in) begin
         state_next.power_control.supply_on_flag = 1'b1;
      end
      state_next.baud = state_next.power_control.baud_doubler;
      state_next.frame = state_next.power_control.serial_frame_select;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_reg <= '0;
         state_reg.mode <= ipdc_pkg::IPDC_RUN;
         state_reg.power_control <= `IPDC_POWER_CONTROL_RESET;
         state_reg.cpu_run <= 1'b1;
         state_reg.periph_run <= 1'b1;
         state_reg.osc_run <= 1'b1;
         state_reg.port <= 8'hFF;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign sfr_rdata_out = state_reg.rdata;
   assign cpu_clk_en_out = cpu_gate_en;
   assign periph_clk_en_out = periph_gate_en;
   assign osc_run_out = state_reg.osc_run;
   assign cpu_hold_out = state_reg.cpu_hold;
   assign internal_reset_out = state_reg.internal_reset;
   assign ram_block_out = state_reg.ram_block;
   assign baud_doubler_out = state_reg.baud;
   assign serial_frame_select_out = state_reg.frame;
   assign port_out = state_reg.port;
endmodule // ipdc_ctrl

// ---- bench/ipdc_ctrl_asserts.sv ----
/*
 Concurrent checks on the ports of the idle and power-down control block.
 Assumes one clock, synchronous active-high reset and the hand-over timing of the block.
*/
`timescale 1ns/1ps
module ipdc_ctrl_asserts #(
   parameter int unsigned WARM_RST_CYCLES = 24
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic reset_pin_in,
   input wire ipdc_pkg::ipdc_sfr_req_t sfr_req_in,
   input wire logic instr_done_in,
   input wire logic irq_pending_in,
   input wire logic [7:0] port_latch_in,
   input wire logic cpu_clk_en_out,
   input wire logic periph_clk_en_out,
   input wire logic osc_run_out,
   input wire logic cpu_hold_out,
   input wire logic internal_reset_out,
   input wire logic ram_block_out,
   input wire logic baud_doubler_out,
   input wire logic [7:0] port_out
);
   localparam logic [7:0] PWR_ADDR = 8'h87;
   logic [7:0] pin_cnt_reg;
   logic acc_ok;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   assign acc_ok = sfr_req_in.wr && sfr_req_in.addr == PWR_ADDR && cpu_clk_en_out
      && !ram_block_out && !reset_pin_in;
   // Counts consecutive cycles of the reset pin held high, saturating.
   always_ff @(posedge clk_in) begin
      if (rst_in || !reset_pin_in) begin
         pin_cnt_reg <= 8'h00;
      end else if (pin_cnt_reg != 8'hFF) begin
         pin_cnt_reg <= pin_cnt_reg + 8'h01;
      end
   end
   // =====================================================================
   // Mode entry and exit.
   sequence s_entry(logic [1:0] m);
      acc_ok && sfr_req_in.wdata[1:0] == m ##1 instr_done_in;
   endsequence
   chk_idle_entry: assert property (s_entry(2'b01) |-> ##2 (!cpu_clk_en_out && periph_clk_en_out))
      else $error("idle entry did not gate the CPU clock");
   chk_pd_entry: assert property (s_entry(2'b11) |-> ##[1:3] (!osc_run_out && !periph_clk_en_out))
      else $error("power-down entry did not stop the oscillator");
   chk_idle_wake: assert property ((!cpu_clk_en_out && periph_clk_en_out && !cpu_hold_out
      && irq_pending_in) |-> ##[1:3] cpu_clk_en_out)
      else $error("pending interrupt did not end idle");
   chk_hold_gates: assert property (cpu_hold_out |-> (!cpu_clk_en_out && osc_run_out))
      else $error("CPU clock ran while held after wake");
   chk_pin_wake: assert property (reset_pin_in |-> ##[1:3] (cpu_clk_en_out && osc_run_out))
      else $error("reset pin did not restore clocks");
   chk_warm_reset: assert property (pin_cnt_reg > WARM_RST_CYCLES + 2 |-> internal_reset_out)
      else $error("internal reset missing after long pin pulse");
   // =====================================================================
   // Ports and register bits.
   chk_reset_ports: assert property (disable iff (1'b0) (rst_in |=> port_out == 8'hFF)
      and (internal_reset_out |-> port_out == 8'hFF))
      else $error("ports not high during reset");
   chk_port_data: assert property (!internal_reset_out ##1 !internal_reset_out
      |-> port_out == $past(port_latch_in))
      else $error("ports do not present latched data");
   chk_baud_bit: assert property (acc_ok |=> baud_doubler_out == $past(sfr_req_in.wdata[7]))
      else $error("baud doubler bit not updated by write");
endmodule // ipdc_ctrl_asserts

bind ipdc_ctrl ipdc_ctrl_asserts #(.WARM_RST_CYCLES(WARM_RST_CYCLES)) u_chk (
   .clk_in(clk_in), .rst_in(rst_in), .reset_pin_in(reset_pin_in), .sfr_req_in(sfr_req_in),
   .instr_done_in(instr_done_in), .irq_pending_in(irq_pending_in),
   .port_latch_in(port_latch_in), .cpu_clk_en_out(cpu_clk_en_out),
   .periph_clk_en_out(periph_clk_en_out), .osc_run_out(osc_run_out),
   .cpu_hold_out(cpu_hold_out), .internal_reset_out(internal_reset_out),
   .ram_block_out(ram_block_out), .baud_doubler_out(baud_doubler_out), .port_out(port_out));

// ---- bench/ipdc_cpu_model.sv ----
/*
 Behavioural CPU core: reports the end of each register-writing instruction.
 Assumes it sits on the same clock and register port as the control block.
*/
`timescale 1ns/1ps
module ipdc_cpu_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic cpu_clk_en_in,
   input wire ipdc_pkg::ipdc_sfr_req_t sfr_req_in,
   output logic instr_done_out
);
   // A write finishes its instruction one cycle later; nothing follows a mode entry.
   always_ff @(posedge clk_in) begin
      instr_done_out <= !rst_in && cpu_clk_en_in && sfr_req_in.wr;
   end
endmodule // ipdc_cpu_model

// ---- bench/ipdc_ctrl_tb.sv ----
/*
 Self-checking bench for the idle and power-down control block.
 Assumes the CPU model in bench/ and the checker bound to the design.
*/
`timescale 1ns/1ps
module ipdc_ctrl_tb;
   localparam logic [7:0] PWR = 8'h87;
   logic clk_in, rst_in, power_on_in, reset_pin_in, instr_done, irq_pending_in;
   logic ext_irq_a_n_in, ext_irq_b_n_in, ext_irq_a_en_in, ext_irq_b_en_in;
   logic adc_idle_mode_in, adc_done_in, cpu_en, per_en, osc, hold, irst, rblk, baud, frame;
   logic [7:0] port_latch_in, rdata, port_out, st;
   ipdc_pkg::ipdc_sfr_req_t req;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   assign st = {frame, baud, irst, rblk, hold, osc, per_en, cpu_en};
   ipdc_cpu_model cpu (.clk_in(clk_in), .rst_in(rst_in), .cpu_clk_en_in(cpu_en),
      .sfr_req_in(req), .instr_done_out(instr_done));
   ipdc_ctrl #(.WARM_RST_CYCLES(24), .OSC_START_CYCLES(16), .RAM_BLOCK_CYCLES(4)) DUT (
      .clk_in(clk_in), .rst_in(rst_in), .power_on_in(power_on_in),
      .reset_pin_in(reset_pin_in), .sfr_req_in(req), .instr_done_in(instr_done),
      .irq_pending_in(irq_pending_in), .ext_irq_a_n_in(ext_irq_a_n_in),
      .ext_irq_b_n_in(ext_irq_b_n_in), .ext_irq_a_en_in(ext_irq_a_en_in),
      .ext_irq_b_en_in(ext_irq_b_en_in), .adc_idle_mode_in(adc_idle_mode_in),
      .adc_done_in(adc_done_in), .port_latch_in(port_latch_in), .sfr_rdata_out(rdata),
      .cpu_clk_en_out(cpu_en), .periph_clk_en_out(per_en), .osc_run_out(osc),
      .cpu_hold_out(hold), .internal_reset_out(irst), .ram_block_out(rblk),
      .baud_doubler_out(baud), .serial_frame_select_out(frame), .port_out(port_out));
   // =====================================================================
   // Tasks.
   task automatic conclude();
      if (failures == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      req = '{1'b1, 1'b0, a, d};
      @(negedge clk_in);
      req.wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_in);
      req = '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk_in);
      req.rd = 1'b0;
      cmp(rdata, exp);
   endtask
   task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
      int n = 0;
      while ((st & m) !== v && n < 200) begin
         @(negedge clk_in);
         n++;
      end
   endtask
   task automatic pin_wake(input logic [7:0] d);
      wr(PWR, d);
      cyc(4);
      reset_pin_in = 1'b1;
      cyc(3);
      cmp(st & 8'h17, 8'h17);
      cyc(25);
      cmp(st & 8'h20, 8'h20);
      cmp(port_out, 8'hFF);
      reset_pin_in = 1'b0;
      wait_st(8'h20, 8'h00);
      // A warm reset clears the software bits but keeps the supply flag as it was.
      rd(PWR, 8'h00);
   endtask
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         conclude();
      end
   end
   // =====================================================================
   // Main sequence.
   initial begin
      {rst_in, ext_irq_a_n_in, ext_irq_b_n_in} = 3'b111;
      {power_on_in, reset_pin_in, irq_pending_in, ext_irq_a_en_in, ext_irq_b_en_in} = 5'h00;
      {adc_idle_mode_in, adc_done_in} = 2'b00;
      req = '0;
      port_latch_in = 8'hA5;
      cyc(6);
      cmp(port_out, 8'hFF);
      rst_in = 1'b0;
      rd(PWR, 8'h10);
      cmp(port_out, 8'hA5);
      wr(PWR, 8'h2C);
      rd(PWR, 8'h2C);
      power_on_in = 1'b1;
      cyc(1);
      power_on_in = 1'b0;
      rd(PWR, 8'h3C);
      wr(PWR, 8'hC0);
      cmp(st, 8'hC7);
      wr(PWR, 8'h0C);
      wr(8'h88, 8'hFF);
      rd(PWR, 8'h0C);
      rd(8'h88, 8'h0C);
      wr(PWR, 8'h0D);
      cyc(3);
      cmp(st, 8'h06);
      port_latch_in = 8'h3C;
      cyc(2);
      cmp(port_out, 8'h3C);
      wr(PWR, 8'h00);
      irq_pending_in = 1'b1;
      wait_st(8'h01, 8'h01);
      irq_pending_in = 1'b0;
      rd(PWR, 8'h0C);
      adc_idle_mode_in = 1'b1;
      wr(PWR, 8'h0D);
      cyc(3);
      adc_done_in = 1'b1;
      cyc(1);
      adc_done_in = 1'b0;
      wait_st(8'h01, 8'h01);
      cmp(st, 8'h07);
      adc_idle_mode_in = 1'b0;
      wr(PWR, 8'h0F);
      cyc(4);
      cmp(st, 8'h00);
      irq_pending_in = 1'b1;
      ext_irq_b_n_in = 1'b0;
      cyc(6);
      cmp(st, 8'h00);
      {irq_pending_in, ext_irq_b_n_in} = 2'b01;
      // The waking line stays low well past oscillator start.
      ext_irq_a_en_in = 1'b1;
      ext_irq_a_n_in = 1'b0;
      wait_st(8'h02, 8'h02);
      cyc(5);
      cmp(st, 8'h0E);
      ext_irq_a_n_in = 1'b1;
      wait_st(8'h01, 8'h01);
      cyc(3);
      cmp(st, 8'h07);
      rd(PWR, 8'h0C);
      pin_wake(8'h01);
      pin_wake(8'h02);
      conclude();
   end
endmodule // ipdc_ctrl_tb
